/* ast_pkg.sv */
// Package: constants and types shared by both ends of the converter link
package ast_pkg;
  // ==========================================================
  // Widths
  localparam int          RES_W        = 10;
  localparam int          ADDR_W       = 4;
  // ==========================================================
  // Timing, clk_sys at 25 MHz
  localparam int          SYS_NS       = 40;
  localparam int          CS_FILT_NS   = 1425;
  localparam int          CS_FILT_CYC  = (CS_FILT_NS + SYS_NS - 1) / SYS_NS;
  localparam int          CONV_NS      = 21000;
  localparam int          CONV_CYC     = CONV_NS / SYS_NS;
  localparam int          ABORT_NS     = 9000;
  localparam int          ABORT_CYC    = ABORT_NS / SYS_NS;
  localparam int          HOST_GAP_CYC = CS_FILT_CYC + 4;
  // ==========================================================
  // Transfer framing, counted in shift-clock edges
  localparam int          EOC_CLK      = 10;
  localparam int          ACQ_CLKS     = 6;
  localparam int          ACQ_START    = EOC_CLK - ACQ_CLKS;
  localparam int          FRAME_MAX    = 16;
  // ==========================================================
  // Self-test channels and their codes
  localparam logic [3:0]  ST_MID_ADDR  = 4'hb;
  localparam logic [3:0]  ST_ZERO_ADDR = 4'hc;
  localparam logic [3:0]  ST_FULL_ADDR = 4'hd;
  localparam logic [9:0]  ST_MID_CODE  = 10'h200;
  localparam logic [9:0]  ST_ZERO_CODE = 10'h000;
  localparam logic [9:0]  ST_FULL_CODE = 10'h3ff;
  localparam logic [9:0]  RES_RST      = 10'h000;
  // ==========================================================
  // State types
  typedef enum logic {CV_IDLE = 1'b0, CV_RUN = 1'b1} ast_conv_t;
  typedef enum logic [2:0] {
    H_IDLE  = 3'b000,
    H_SETUP = 3'b001,
    H_LOW   = 3'b011,
    H_HIGH  = 3'b010,
    H_END   = 3'b110
  } ast_host_st_t;
endpackage : ast_pkg

/* ast_link_if.sv */
// Interface: the four-wire serial link plus conversion-done flag
interface ast_link_if;
  logic cs_n;
  logic io_clk;
  logic addr;
  logic dout_o;
  logic dout_oe;
  logic dout_w;
  logic eoc;

  // Released line shows the inverted bit, so a stray sample is caught
  assign dout_w = dout_oe ? dout_o : ~dout_o;

  modport dev (input cs_n, input io_clk, input addr, output dout_o, output dout_oe, output eoc);
  modport host (output cs_n, output io_clk, output addr, input dout_w, input eoc);
endinterface : ast_link_if

/* ast_dev_end.sv */
// Converter end: chip-select filter, serial shifter and conversion sequencer
// Operation
// - Ignore inputs until chip select stays filtered
// - Host waits setup time before addressing
// - Chip select rise stops shifting after filter
// - Ten-clock transfers, framed or unframed
// - Framed transfers of eleven to sixteen clocks
// - Unframed long transfers use exactly sixteen clocks
// - Unframed ten or sixteen clocks, short or long
// - Unframed short: wait done flag first
// - Eleventh rise precedes end of conversion
// - Done flag low at tenth fall
// - Acquisition spans six shift-clock periods
// - Three addresses select self-test codes
module ast_dev_end
  import ast_pkg::*;
(
  input  wire logic              clk_sys,  // System clock
  input  wire logic              rstn,     // Async reset, active low
  ast_link_if.dev                lnk,      // Serial link
  input  wire logic [RES_W-1:0]  ain_code, // Level of the selected channel
  output logic      [ADDR_W-1:0] ch_sel,   // Channel being sampled
  output logic                   acq,      // Acquisition window open
  output logic                   busy      // Conversion running
);

  // ==========================================================
  // Input synchronisers
  logic [1:0] cs_sync_ff;
  logic [2:0] ck_sync_ff;
  logic [1:0] ad_sync_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cs_sync_ff <= 2'h3;
      ck_sync_ff <= 3'h0;
      ad_sync_ff <= 2'h0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[0], lnk.cs_n};
      ck_sync_ff <= {ck_sync_ff[1:0], lnk.io_clk};
      ad_sync_ff <= {ad_sync_ff[0], lnk.addr};
    end
  end

  logic cs_s;
  logic ck_rise;
  logic ck_fall;
  logic ad_s;

  assign cs_s    = cs_sync_ff[1];
  assign ad_s    = ad_sync_ff[1];
  assign ck_rise = ck_sync_ff[1] & ~ck_sync_ff[2];
  assign ck_fall = ~ck_sync_ff[1] & ck_sync_ff[2];

  // ==========================================================
  // Chip-select glitch filter
  logic       cs_filt_ff;
  logic       nxt_cs_filt;
  logic [5:0] fcnt_ff;
  logic [5:0] nxt_fcnt;
  logic       cs_flip;

  always_comb begin
    nxt_cs_filt = cs_filt_ff;
    nxt_fcnt    = 6'h00;
    cs_flip     = 1'b0;
    // level must hold for the filter time
    // rise is honoured after the same delay
    if (cs_s != cs_filt_ff) begin
      if (fcnt_ff == 6'(CS_FILT_CYC - 1)) begin
        nxt_cs_filt = cs_s;
        cs_flip     = 1'b1;
      end else begin
        nxt_fcnt = fcnt_ff + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cs_filt_ff <= 1'b1;
      fcnt_ff    <= 6'h00;
    end else begin
      cs_filt_ff <= nxt_cs_filt;
      fcnt_ff    <= nxt_fcnt;
    end
  end

  // ==========================================================
  // Self-test substitution
  function automatic logic [RES_W-1:0] ast_code(input logic [ADDR_W-1:0] ch,
                                                input logic [RES_W-1:0]  lvl);
    logic [RES_W-1:0] code;
    code = lvl;
    unique case (ch)
      ST_MID_ADDR:  code = ST_MID_CODE;
      ST_ZERO_ADDR: code = ST_ZERO_CODE;
      ST_FULL_ADDR: code = ST_FULL_CODE;
      default:      code = lvl;
    endcase
    return code;
  endfunction : ast_code

  // ==========================================================
  // Transfer and conversion sequencer
  ast_conv_t         cv_ff;
  ast_conv_t         nxt_cv;
  logic [9:0]        tmr_ff;
  logic [9:0]        nxt_tmr;
  logic [4:0]        cnt_ff;
  logic [4:0]        nxt_cnt;
  logic              r11_ff;
  logic              nxt_r11;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [ADDR_W-1:0] ch_ff;
  logic [ADDR_W-1:0] nxt_ch;
  logic [RES_W-1:0]  shreg_ff;
  logic [RES_W-1:0]  nxt_shreg;
  logic [RES_W-1:0]  res_ff;
  logic [RES_W-1:0]  nxt_res;
  logic [RES_W-1:0]  samp_ff;
  logic [RES_W-1:0]  nxt_samp;
  logic              acq_ff;
  logic              nxt_acq;
  logic              eoc_ff;
  logic              nxt_eoc;
  logic              oe_ff;
  logic              nxt_oe;

  always_comb begin
    nxt_cv    = cv_ff;
    nxt_tmr   = tmr_ff;
    nxt_cnt   = cnt_ff;
    nxt_r11   = r11_ff;
    nxt_addr  = addr_ff;
    nxt_ch    = ch_ff;
    nxt_shreg = shreg_ff;
    nxt_res   = res_ff;
    nxt_samp  = samp_ff;
    nxt_acq   = acq_ff;
    nxt_eoc   = eoc_ff;
    nxt_oe    = oe_ff;

    // Conversion timer runs on the system clock, not the shift clock
    if (cv_ff == CV_RUN) begin
      nxt_tmr = tmr_ff + 10'h001;
      if (tmr_ff == 10'(CONV_CYC - 1)) begin
        nxt_cv    = CV_IDLE;
        nxt_res   = samp_ff;
        nxt_shreg = samp_ff;
        nxt_eoc   = 1'b1;
        // without the eleventh rise the count is lost
        if (cnt_ff == 5'(EOC_CLK) && !r11_ff) begin
          nxt_cnt = 5'h00;
        end
      end
    end

    if (cs_flip && cs_filt_ff) begin
      // Selected: new frame starts with the MSB of the last result
      nxt_cnt   = 5'h00;
      nxt_r11   = 1'b0;
      nxt_oe    = 1'b1;
      nxt_shreg = nxt_res;
      // early fall abandons the running conversion
      if (cv_ff == CV_RUN && tmr_ff < 10'(ABORT_CYC)) begin
        nxt_cv  = CV_IDLE;
        nxt_eoc = 1'b1;
      end
    end else if (cs_flip) begin
      // deselect ends the frame, any length up to sixteen
      nxt_cnt   = 5'h00;
      nxt_r11   = 1'b0;
      nxt_oe    = 1'b0;
      nxt_acq   = 1'b0;
      nxt_shreg = nxt_res;
    end else if (!cs_filt_ff) begin
      // address enters MSB first on rising edges
      if (ck_rise && cnt_ff < 5'(ADDR_W)) begin
        nxt_addr = {addr_ff[ADDR_W-2:0], ad_s};
      end
      if (ck_rise && cnt_ff == 5'(EOC_CLK)) begin
        nxt_r11 = 1'b1;
      end
      if (ck_fall) begin
        nxt_cnt = cnt_ff + 5'h01;
        // result leaves MSB first on falling edges
        if (cnt_ff < 5'(RES_W - 1)) begin
          nxt_shreg = {shreg_ff[RES_W-2:0], 1'b0};
        end
        // sampling opens six periods before the tenth fall
        if (cnt_ff == 5'(ACQ_START - 1)) begin
          nxt_acq = 1'b1;
          nxt_ch  = addr_ff;
        end
        // tenth fall drops the done flag and starts conversion
        if (cnt_ff == 5'(EOC_CLK - 1)) begin
          nxt_acq  = 1'b0;
          nxt_eoc  = 1'b0;
          nxt_cv   = CV_RUN;
          nxt_tmr  = 10'h000;
          // self-test addresses replace the channel level
          nxt_samp = ast_code(ch_ff, ain_code);
        end
        // sixteenth fall closes an unframed transfer
        if (cnt_ff == 5'(FRAME_MAX - 1)) begin
          nxt_cnt = 5'h00;
          nxt_r11 = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cv_ff    <= CV_IDLE;
      tmr_ff   <= 10'h000;
      cnt_ff   <= 5'h00;
      r11_ff   <= 1'b0;
      addr_ff  <= 4'h0;
      ch_ff    <= 4'h0;
      shreg_ff <= RES_RST;
      res_ff   <= RES_RST;
      samp_ff  <= RES_RST;
      acq_ff   <= 1'b0;
      eoc_ff   <= 1'b1;
      oe_ff    <= 1'b0;
    end else begin
      cv_ff    <= nxt_cv;
      tmr_ff   <= nxt_tmr;
      cnt_ff   <= nxt_cnt;
      r11_ff   <= nxt_r11;
      addr_ff  <= nxt_addr;
      ch_ff    <= nxt_ch;
      shreg_ff <= nxt_shreg;
      res_ff   <= nxt_res;
      samp_ff  <= nxt_samp;
      acq_ff   <= nxt_acq;
      eoc_ff   <= nxt_eoc;
      oe_ff    <= nxt_oe;
    end
  end

  // ==========================================================
  // Outputs
  assign lnk.dout_o  = shreg_ff[RES_W-1];
  assign lnk.dout_oe = oe_ff;
  assign lnk.eoc     = eoc_ff;
  assign ch_sel      = ch_ff;
  assign acq         = acq_ff;
  assign busy        = cv_ff;

endmodule : ast_dev_end

/* ast_host_end.sv */
// Host end: serial port sequencer and result FIFO
// ==========================================================
// Shift-register FIFO, head word always in flops
module ast_fifo #(
  parameter int W     = 10,
  parameter int DEPTH = 8
) (
  input  wire logic         clk_sys,   // System clock
  input  wire logic         rstn,      // Async reset, active low
  input  wire logic         in_valid,  // Word offered
  output logic              in_ready,  // Room for a word
  input  wire logic [W-1:0] in_data,   // Word in
  output logic              out_valid, // Head word present
  input  wire logic         out_ready, // Sink takes head
  output logic      [W-1:0] out_data   // Head word
);
  // Elaboration-time size check
  if (DEPTH < 2 || W < 1) begin : g_bad_size
    $error("ast_fifo: bad size");
  end

  logic [W-1:0]     mem_ff [DEPTH];
  logic [W-1:0]     nxt_mem [DEPTH];
  logic [DEPTH-1:0] vld_ff;
  logic [DEPTH-1:0] nxt_vld;

  always_comb begin
    logic done;
    done    = 1'b0;
    nxt_mem = mem_ff;
    nxt_vld = vld_ff;
    if (out_ready && vld_ff[0]) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        nxt_mem[i] = mem_ff[i+1];
        nxt_vld[i] = vld_ff[i+1];
      end
      nxt_vld[DEPTH-1] = 1'b0;
    end
    // No write while full, so a word is never dropped
    if (in_valid && !vld_ff[DEPTH-1]) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (!nxt_vld[i] && !done) begin
          nxt_mem[i] = in_data;
          nxt_vld[i] = 1'b1;
          done       = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      vld_ff <= '0;
      for (int i = 0; i < DEPTH; i++) mem_ff[i] <= '0;
    end else begin
      vld_ff <= nxt_vld;
      mem_ff <= nxt_mem;
    end
  end

  assign in_ready  = ~vld_ff[DEPTH-1];
  assign out_valid = vld_ff[0];
  assign out_data  = mem_ff[0];
endmodule : ast_fifo

// ==========================================================
// Host serial sequencer
module ast_host_end
  import ast_pkg::*;
#(
  parameter int HALF_CYC   = 4,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic              clk_sys,    // System clock
  input  wire logic              rstn,       // Async reset, active low
  ast_link_if.host               lnk,        // Serial link
  input  wire logic              cmd_valid,  // Transfer request
  output logic                   cmd_ready,  // Request taken when high
  input  wire logic [ADDR_W-1:0] cmd_chan,   // Channel address to send
  input  wire logic [4:0]        cmd_len,    // Shift clocks, 10 to 16
  input  wire logic              cmd_framed, // Frame with chip select
  output logic                   res_valid,  // Result word ready
  input  wire logic              res_ready,  // Result word taken
  output logic      [RES_W-1:0]  res_data    // Result word
);
  // Shift-clock half period must fit the 8-bit timer and the sync delay
  if (HALF_CYC < 4 || HALF_CYC > 255) begin : g_bad_half
    $error("ast_host_end: bad HALF_CYC");
  end

  logic [1:0] eoc_sync_ff;
  logic [1:0] dout_sync_ff;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      eoc_sync_ff  <= 2'h0;
      dout_sync_ff <= 2'h0;
    end else begin
      eoc_sync_ff  <= {eoc_sync_ff[0], lnk.eoc};
      dout_sync_ff <= {dout_sync_ff[0], lnk.dout_w};
    end
  end

  ast_host_st_t      st_ff, nxt_st;
  logic [7:0]        tcnt_ff, nxt_tcnt;
  logic [4:0]        bit_ff, nxt_bit;
  logic [4:0]        len_ff, nxt_len;
  logic              framed_ff, nxt_framed;
  logic [ADDR_W-1:0] sh_ff, nxt_sh;
  logic [RES_W-1:0]  rx_ff, nxt_rx;
  logic              cs_n_ff, nxt_cs_n;
  logic              ck_ff, nxt_ck;
  logic              ad_ff, nxt_ad;
  logic              rdy_ff, nxt_rdy;
  logic              push_ff, nxt_push;
  logic              fifo_rdy;

  always_comb begin
    nxt_st     = st_ff;
    nxt_tcnt   = tcnt_ff + 8'h01;
    nxt_bit    = bit_ff;
    nxt_len    = len_ff;
    nxt_framed = framed_ff;
    nxt_sh     = sh_ff;
    nxt_rx     = rx_ff;
    nxt_cs_n   = cs_n_ff;
    nxt_ck     = ck_ff;
    nxt_ad     = ad_ff;
    nxt_rdy    = 1'b0;
    nxt_push   = 1'b0;
    unique case (st_ff)
      H_IDLE: begin
        // start only once the last conversion is done
        nxt_rdy = eoc_sync_ff[1] & fifo_rdy & ~(cmd_valid & rdy_ff);
        if (cmd_valid && rdy_ff) begin
          nxt_framed = cmd_framed;
          nxt_sh     = cmd_chan;
          nxt_bit    = 5'h00;
          nxt_tcnt   = 8'h00;
          // unframed length is 10 or exactly 16
          if (cmd_len <= 5'(EOC_CLK)) nxt_len = 5'(EOC_CLK);
          else if (!cmd_framed || cmd_len > 5'(FRAME_MAX)) nxt_len = 5'(FRAME_MAX);
          else nxt_len = cmd_len;
          if (cmd_framed && !cs_n_ff) begin
            // Leaving unframed mode: deselect first, request dropped
            nxt_cs_n = 1'b1;
            nxt_st   = H_END;
          end else begin
            nxt_cs_n = 1'b0;
            nxt_st   = H_SETUP;
          end
        end
      end
      H_SETUP: begin
        // no address before the setup interval
        if (tcnt_ff == 8'(HOST_GAP_CYC - 1)) begin
          nxt_ad   = sh_ff[ADDR_W-1];
          nxt_tcnt = 8'h00;
          nxt_st   = H_LOW;
        end
      end
      H_LOW: begin
        if (tcnt_ff == 8'(HALF_CYC - 1)) begin
          nxt_ck   = 1'b1;
          nxt_tcnt = 8'h00;
          nxt_st   = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tcnt_ff == 8'(HALF_CYC - 1)) begin
          nxt_ck   = 1'b0;
          nxt_tcnt = 8'h00;
          nxt_bit  = bit_ff + 5'h01;
          nxt_sh   = {sh_ff[ADDR_W-2:0], 1'b0};
          nxt_ad   = sh_ff[ADDR_W-2];
          if (bit_ff < 5'(RES_W)) nxt_rx = {rx_ff[RES_W-2:0], dout_sync_ff[1]};
          if (bit_ff + 5'h01 == len_ff) begin
            nxt_push = 1'b1;
            // unframed transfers keep chip select low
            nxt_cs_n = framed_ff ? 1'b1 : 1'b0;
            nxt_st   = H_END;
          end else begin
            nxt_st = H_LOW;
          end
        end
      end
      H_END: begin
        // Lets the done flag fall and the deselect settle
        if (tcnt_ff == 8'(HOST_GAP_CYC - 1)) begin
          nxt_tcnt = 8'h00;
          nxt_st   = H_IDLE;
        end
      end
      default: nxt_st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_ff     <= H_IDLE;
      tcnt_ff   <= 8'h00;
      bit_ff    <= 5'h00;
      len_ff    <= 5'h0a;
      framed_ff <= 1'b1;
      sh_ff     <= 4'h0;
      rx_ff     <= RES_RST;
      cs_n_ff   <= 1'b1;
      ck_ff     <= 1'b0;
      ad_ff     <= 1'b0;
      rdy_ff    <= 1'b0;
      push_ff   <= 1'b0;
    end else begin
      st_ff     <= nxt_st;
      tcnt_ff   <= nxt_tcnt;
      bit_ff    <= nxt_bit;
      len_ff    <= nxt_len;
      framed_ff <= nxt_framed;
      sh_ff     <= nxt_sh;
      rx_ff     <= nxt_rx;
      cs_n_ff   <= nxt_cs_n;
      ck_ff     <= nxt_ck;
      ad_ff     <= nxt_ad;
      rdy_ff    <= nxt_rdy;
      push_ff   <= nxt_push;
    end
  end

  // Full FIFO holds off new transfers, never loses a result
  ast_fifo #(
    .W     (RES_W),
    .DEPTH (FIFO_DEPTH)
  ) ast_fifo_inst (
    .clk_sys   (clk_sys),
    .rstn      (rstn),
    .in_valid  (push_ff),
    .in_ready  (fifo_rdy),
    .in_data   (rx_ff),
    .out_valid (res_valid),
    .out_ready (res_ready),
    .out_data  (res_data)
  );

  assign lnk.cs_n   = cs_n_ff;
  assign lnk.io_clk = ck_ff;
  assign lnk.addr   = ad_ff;
  assign cmd_ready  = rdy_ff;
endmodule : ast_host_end

/* ast_link_chk.sv */
// Checker: timing relations on the converter link
module ast_link_chk
  import ast_pkg::*;
(
  input wire logic clk_sys, // System clock
  input wire logic rstn,    // Async reset, active low
  input wire logic cs_n,    // Chip select, low active
  input wire logic io_clk,  // Shift clock
  input wire logic addr,    // Address bit
  input wire logic dout_o,  // Result bit
  input wire logic dout_oe, // Result drive enable
  input wire logic dout_w,  // Resolved result line
  input wire logic eoc      // Conversion done
);
  // ==========
  // Frame bookkeeping
  logic [5:0] cs_cnt_ff, nxt_cs_cnt;
  logic [4:0] idle_ff, nxt_idle, rise_ff, nxt_rise, fall_ff, nxt_fall, rbase;
  logic       io_q_ff, rise, fall, fresh;

  // Long shift-clock idle marks a new transfer
  always_comb begin
    rise = io_clk & ~io_q_ff;
    fall = ~io_clk & io_q_ff;
    fresh = idle_ff >= 5'h14;
    rbase = fresh ? 5'h00 : rise_ff;
    nxt_cs_cnt = cs_n ? 6'h00 : cs_cnt_ff + {5'h00, cs_cnt_ff != 6'h3f};
    nxt_idle = (rise | fall) ? 5'h00 : idle_ff + {4'h0, idle_ff != 5'h1f};
    nxt_rise = rise ? rbase + 5'h01 : rise_ff;
    nxt_fall = (rise & fresh) ? 5'h00 : fall_ff + {4'h0, fall};
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      io_q_ff <= 1'b0;
      cs_cnt_ff <= 6'h00;
      idle_ff <= 5'h1f;
      rise_ff <= 5'h00;
      fall_ff <= 5'h00;
    end else begin
      io_q_ff <= io_clk;
      cs_cnt_ff <= nxt_cs_cnt;
      idle_ff <= nxt_idle;
      rise_ff <= nxt_rise;
      fall_ff <= nxt_fall;
    end
  end

  // ==========
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  property p_oe_on; $fell(cs_n) |-> ##[34:42] dout_oe; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("result line not enabled after chip select fall");
  property p_oe_rise; $rose(dout_oe) |-> !cs_n && cs_cnt_ff >= 34 && cs_cnt_ff <= 44; endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("result line enabled before filter time");
  property p_oe_off; $rose(cs_n) |-> ##[34:42] !dout_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("result line still driven after chip select rise");
  property p_oe_fall; $fell(dout_oe) |-> cs_n && $past(cs_n, 30); endproperty
  a_oe_fall: assert property (p_oe_fall)
    else $error("result line released without filtered chip select");
  property p_setup; rise |-> cs_cnt_ff >= CS_FILT_CYC; endproperty
  a_setup: assert property (p_setup)
    else $error("shift clock before chip select setup");
  property p_idle; cs_n |-> !io_clk; endproperty
  a_idle: assert property (p_idle)
    else $error("shift clock high while deselected");
  property p_len; rise |-> rbase < FRAME_MAX; endproperty
  a_len: assert property (p_len)
    else $error("more than sixteen shift clocks in a transfer");
  property p_wait; rise && !eoc |-> rbase >= EOC_CLK; endproperty
  a_wait: assert property (p_wait)
    else $error("transfer started before conversion done");
  property p_done_low; $fell(eoc) |-> fall_ff == EOC_CLK; endproperty
  a_done_low: assert property (p_done_low)
    else $error("done flag fell off the tenth falling edge");
  property p_conv; $fell(eoc) |=> !eoc [*8] ##[512:522] eoc; endproperty
  a_conv: assert property (p_conv)
    else $error("conversion length wrong");
  property p_dout_hold; io_clk |-> $stable(dout_w); endproperty
  a_dout_hold: assert property (p_dout_hold)
    else $error("result line moved while shift clock high");
  property p_addr_hold; io_clk |-> $stable(addr); endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address line moved while shift clock high");
endmodule : ast_link_chk

/* adc_serial_transfer_control_bench.sv */
// Testbench: host end and converter end joined over one link
module adc_serial_transfer_control_bench
  import ast_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_sys, rstn, cmd_valid, cmd_ready, cmd_framed;
  logic              res_valid, res_ready, acq, busy;
  logic [ADDR_W-1:0] cmd_chan, ch_sel;
  logic [4:0]        cmd_len;
  logic [RES_W-1:0]  res_data, lvl, last;
  int                n_fail, comparisons;

  ast_link_if lnk_if ();
  // Second link: bench plays a faulty host
  ast_link_if lnk2_if ();
  ast_host_end #(.HALF_CYC(4), .FIFO_DEPTH(8)) ast_host_end_inst (.clk_sys(clk_sys),
    .rstn(rstn), .lnk(lnk_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_chan(cmd_chan), .cmd_len(cmd_len), .cmd_framed(cmd_framed),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
  ast_dev_end ast_dev_end_inst (.clk_sys(clk_sys), .rstn(rstn), .lnk(lnk_if),
    .ain_code(lvl), .ch_sel(ch_sel), .acq(acq), .busy(busy));
  ast_dev_end ast_dev_end_inst2 (.clk_sys(clk_sys), .rstn(rstn), .lnk(lnk2_if),
    .ain_code(lvl), .ch_sel(), .acq(), .busy());
  ast_link_chk ast_link_chk_inst (.clk_sys(clk_sys), .rstn(rstn), .cs_n(lnk_if.cs_n),
    .io_clk(lnk_if.io_clk), .addr(lnk_if.addr), .dout_o(lnk_if.dout_o),
    .dout_oe(lnk_if.dout_oe), .dout_w(lnk_if.dout_w), .eoc(lnk_if.eoc));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // ==========
  // Checking and closing
  task automatic chk_word(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({9'h000, got}, {9'h000, exp});
  endtask : chk_bit

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  function automatic logic [9:0] code_of(input logic [3:0] ch);
    case (ch)
      ST_MID_ADDR:  return ST_MID_CODE;
      ST_ZERO_ADDR: return ST_ZERO_CODE;
      ST_FULL_ADDR: return ST_FULL_CODE;
      default:      return {2'h2, ch, ~ch};
    endcase
  endfunction : code_of

  // ==========
  // User-side drivers
  task automatic send(input logic [3:0] ch, input logic [4:0] len, input logic fr);
    @(posedge clk_sys);
    cmd_chan <= ch;
    cmd_len <= len;
    cmd_framed <= fr;
    cmd_valid <= 1'b1;
    repeat (3000) begin
      @(posedge clk_sys);
      if (cmd_ready) break;
    end
    chk_bit(cmd_ready, 1'b1);
    cmd_valid <= 1'b0;
    // Level moves only once the previous conversion has sampled it
    lvl <= {2'h2, ch, ~ch};
  endtask : send

  task automatic get(input logic [9:0] exp);
    @(posedge clk_sys);
    res_ready <= 1'b1;
    repeat (3000) begin
      @(posedge clk_sys);
      if (res_valid) break;
    end
    chk_bit(res_valid, 1'b1);
    chk_word(res_data, exp);
    res_ready <= 1'b0;
  endtask : get

  // Result carries the previous conversion
  task automatic xfer(input logic [3:0] ch, input logic [4:0] len, input logic fr);
    send(ch, len, fr);
    get(last);
    chk_word({6'h00, ch_sel}, {6'h00, ch});
    repeat (8) @(posedge clk_sys);
    chk_bit(busy, 1'b1);
    chk_bit(lnk_if.eoc, 1'b0);
    chk_bit(acq, 1'b0);
    last = code_of(ch);
  endtask : xfer

  // ==========
  // Scenarios
  task automatic t_glitch();
    @(posedge clk_sys);
    lnk2_if.cs_n <= 1'b0;
    repeat (20) @(posedge clk_sys);
    lnk2_if.cs_n <= 1'b1;
    repeat (30) @(posedge clk_sys);
    chk_bit(lnk2_if.dout_oe, 1'b0);
    lnk2_if.cs_n <= 1'b0;
    repeat (60) @(posedge clk_sys);
    chk_bit(lnk2_if.dout_oe, 1'b1);
    lnk2_if.cs_n <= 1'b1;
    repeat (60) @(posedge clk_sys);
    chk_bit(lnk2_if.dout_oe, 1'b0);
  endtask : t_glitch

  // Quick reselect after the tenth fall abandons the conversion
  task automatic t_abort();
    @(posedge clk_sys);
    lnk2_if.cs_n <= 1'b0;
    repeat (44) @(posedge clk_sys);
    for (int k = 0; k < 10; k++) begin
      lnk2_if.io_clk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      lnk2_if.io_clk <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    lnk2_if.cs_n <= 1'b1;
    repeat (45) @(posedge clk_sys);
    chk_bit(lnk2_if.eoc, 1'b0);
    lnk2_if.cs_n <= 1'b0;
    repeat (50) @(posedge clk_sys);
    chk_bit(lnk2_if.eoc, 1'b1);
    lnk2_if.cs_n <= 1'b1;
    repeat (60) @(posedge clk_sys);
  endtask : t_abort

  // Every framed length, self-test channels included
  task automatic t_framed();
    for (int n = 10; n <= 16; n++) begin
      xfer(4'(n - 3), 5'(n), 1'b1);
    end
  endtask : t_framed

  task automatic t_unframed();
    xfer(4'h0, 5'd10, 1'b0);
    xfer(4'h3, 5'd16, 1'b0);
    xfer(4'hd, 5'd10, 1'b0);
    xfer(4'h1, 5'd16, 1'b0);
  endtask : t_unframed

  // Framed request while chip select is low is consumed without a result
  task automatic t_refused();
    send(4'h5, 5'd12, 1'b1);
    repeat (200) @(posedge clk_sys);
    chk_bit(res_valid, 1'b0);
    chk_bit(lnk_if.cs_n, 1'b1);
    xfer(4'h2, 5'd11, 1'b1);
  endtask : t_refused

  // Fill the result buffer while the sink stalls, then drain it
  task automatic t_fifo();
    logic [9:0] exp_q[8];
    for (int k = 0; k < 8; k++) begin
      send(4'(k), 5'd10, 1'b1);
      exp_q[k] = last;
      last = code_of(4'(k));
    end
    repeat (1200) @(posedge clk_sys);
    chk_bit(cmd_ready, 1'b0);
    for (int k = 0; k < 8; k++) begin
      get(exp_q[k]);
    end
  endtask : t_fifo

  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_chan = 4'h0;
    cmd_len = 5'd10;
    cmd_framed = 1'b1;
    res_ready = 1'b0;
    lvl = 10'h000;
    lnk2_if.cs_n = 1'b1;
    lnk2_if.io_clk = 1'b0;
    lnk2_if.addr = 1'b0;
    last = RES_RST;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk_bit(lnk_if.eoc, 1'b1);
    chk_bit(lnk_if.dout_oe, 1'b0);
    t_glitch();
    t_abort();
    t_framed();
    t_unframed();
    t_refused();
    t_fifo();
    stop_test();
  end

  // Run needs about 14000 cycles
  initial begin
    repeat (60000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end
endmodule : adc_serial_transfer_control_bench
